/* File: common/wdg_pkg.sv */
// Package of constants and state carriers for the watchdog block
package wdg_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ     = 200_000_000;
    localparam int unsigned OSC_FREQ_HZ     = 1_000_000;
    // Divider from system clock down to the watchdog oscillator rate
    localparam int unsigned OSC_DIV         = CLK_FREQ_HZ / OSC_FREQ_HZ;
    // Turn-off enable lifetime in system clocks
    localparam int unsigned TOE_HOLD_CYC    = 4;
    // Shortest timeout in oscillator cycles (16K), doubles per code
    localparam int unsigned BASE_PERIOD     = 16_384;
    // Width of the system reset pulse in system clocks
    localparam int unsigned RST_PULSE_CYC   = 16;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned CNT_W           = 22;
    localparam int unsigned OSC_CNT_W       = 16;
    localparam int unsigned ADR_W           = 8;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL      = 8'h00;
    localparam logic [7:0] OFS_RESTART      = 8'h04;
    localparam logic [7:0] OFS_STATUS       = 8'h08;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int unsigned BIT_TOE         = 4;
    localparam int unsigned BIT_EN          = 3;
    localparam int unsigned PS_LSB          = 0;
    localparam int unsigned PS_W            = 3;

    // Status register fields
    localparam int unsigned BIT_WDT_FLAG    = 31;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic            RST_EN      = 1'b0;
    localparam logic            RST_TOE     = 1'b0;
    localparam logic [2:0]      RST_PS      = 3'h0;

    // ------------------------------------------------------------
    // State carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                   ack;
        logic [31:0]            rdata;
        logic                   en;
        logic                   toe;
        logic [2:0]             toe_cnt;
        logic [PS_W-1:0]        ps;
        logic [CNT_W-1:0]       cnt;
        logic                   rst_out;
        logic [4:0]             rst_cnt;
        logic                   wdt_flag;
    } wdg_state_s;

    typedef struct packed {
        logic [OSC_CNT_W-1:0]   div_cnt;
        logic                   tick;
    } wdg_osc_s;

endpackage

/* File: testbench/wdg_properties.sv */
// Checker of bus handshake, read values and reset pulse of the watchdog
`timescale 1ns/1ps
module wdg_properties (
    // Clock and reset
    input  wire logic                      CLOCK_I,
    input  wire logic                      RESET_I,
    // Bus and reset request
    input  wire logic [wdg_pkg::ADR_W-1:0] WB_ADR_I,
    input  wire logic [31:0]               WB_DAT_I,
    input  wire logic [3:0]                WB_SEL_I,
    input  wire logic                      WB_WE_I,
    input  wire logic                      WB_CYC_I,
    input  wire logic                      WB_STB_I,
    input  wire logic                      WB_ACK_O,
    input  wire logic [31:0]               WB_DAT_O,
    input  wire logic                      SYS_RESET_O
);
    // ------------------------------------------------------------
    // Named steps
    // ------------------------------------------------------------
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    sequence s_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_rd(a);
        s_take ##0 (!WB_WE_I && WB_ADR_I[7:2] == a);
    endsequence
    // Restart write must beat a tick landing in the same cycle
    sequence s_restart;
        s_take ##0 (WB_WE_I && WB_SEL_I[0] && WB_ADR_I[7:2] == 6'h01);
    endsequence
    // Pulse is 16 cycles; split because repetitions stay small
    sequence s_pulse;
        SYS_RESET_O [*8] ##1 SYS_RESET_O [*8] ##1 !SYS_RESET_O;
    endsequence
    chk_ack_latency: assert property (s_take |=> WB_ACK_O)
        else $error("ack missing after request");
    chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (WB_ACK_O |->
        $past(WB_CYC_I) && $past(WB_STB_I))
        else $error("ack without request");
    chk_rsvd_zero: assert property (s_rd(6'h00) |=> WB_DAT_O[7:5] == 3'h0)
        else $error("reserved control bits nonzero");
    chk_restart_read: assert property (s_rd(6'h01) |=> WB_DAT_O == 32'h0000_0000)
        else $error("restart place reads nonzero");
    chk_dat_hold: assert property (
        !(WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I) |=>
        $stable(WB_DAT_O))
        else $error("read data changed without read");
    chk_restart_wins: assert property (s_restart |=> !$rose(SYS_RESET_O))
        else $error("reset raised on restart");
    chk_pulse_width: assert property ($rose(SYS_RESET_O) |-> s_pulse)
        else $error("reset pulse width wrong");
endmodule

bind wdg_top wdg_properties u_wdg_properties (
    .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .WB_DAT_O(WB_DAT_O), .SYS_RESET_O(SYS_RESET_O));

/* File: testbench/wdg_top_tb_top.sv */
// Self-checking bench for the watchdog with guarded disable
`timescale 1ns/1ps
module wdg_top_tb_top;
    // ------------------------------------------------------------
    // Short counts keep the whole period sweep brief
    // ------------------------------------------------------------
    localparam int DIV  = 4;
    localparam int BASE = 8;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic [7:0]  adr  = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic        we   = 1'b0;
    logic        cyc  = 1'b0;
    logic [3:0]  sel  = 4'h1;
    logic [3:0]  lanes = 4'h1;
    logic        ack;
    logic [31:0] rdat;
    logic        sys_rst;
    int          failures = 0;
    int          checks_done = 0;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    wdg_top #(.OSC_DIV(DIV), .BASE_PERIOD(BASE)) u_wdg_top (
        .CLOCK_I(clk), .RESET_I(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_ACK_O(ack), .WB_DAT_O(rdat), .SYS_RESET_O(sys_rst));
    task automatic print_verdict();
        if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One classic cycle, bounded wait, then one idle cycle
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        sel <= lanes;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            failures++;
            print_verdict();
        end else begin
            q = rdat;
            cyc <= 1'b0;
            @(posedge clk);
        end
    endtask
    // Counts cycles in which the reset request shows up
    task automatic watch(int len, inout int hits);
        repeat (len) begin
            @(posedge clk);
            if (sys_rst !== 1'b0) hits++;
        end
    endtask
    task automatic t_reset();
        logic [31:0] q;
        bus(0, 8'h00, '0, q);
        check("control reset", q, 32'h0000_0000);
        bus(0, 8'h40, '0, q);
        check("unmapped read", q, 32'h0000_0000);
        // Write with lane 0 off must leave control untouched
        lanes = 4'hE;
        bus(1, 8'h00, 32'h0000_001F, q);
        lanes = 4'h1;
        bus(0, 8'h00, '0, q);
        check("lane off write", q, 32'h0000_0000);
    endtask
    task automatic t_periods();
        logic [31:0] q;
        int c;
        int p;
        for (int s = 0; s < 8; s++) begin
            p = BASE << s;
            bus(1, 8'h00, 32'h0000_0008 | 32'(s), q);
            bus(1, 8'h04, '0, q);
            c = 0;
            while (sys_rst !== 1'b1 && c < p * DIV) begin
                @(posedge clk);
                c++;
            end
            check("timeout early", c >= (p - 1) * DIV, 1'b1);
            check("timeout late", sys_rst, 1'b1);
            repeat (17) @(posedge clk);
            check("pulse end", sys_rst, 1'b0);
        end
    endtask
    task automatic t_restart();
        logic [31:0] q;
        int hits;
        hits = 0;
        bus(1, 8'h00, 32'h0000_0009, q);
        repeat (12) begin
            bus(1, 8'h04, '0, q);
            watch(16, hits);
        end
        check("restart held", hits, 0);
    endtask
    // Bare clear, clear after expiry, then clear inside the window
    task automatic t_disable();
        logic [31:0] q;
        int hits;
        hits = 0;
        bus(1, 8'h04, '0, q);
        bus(1, 8'h00, 32'h0000_0001, q);
        bus(0, 8'h00, '0, q);
        check("bare clear", q, 32'h0000_0009);
        bus(1, 8'h00, 32'h0000_00F9, q);
        bus(0, 8'h00, '0, q);
        check("turnoff set", q, 32'h0000_0019);
        bus(1, 8'h00, 32'h0000_0001, q);
        bus(0, 8'h00, '0, q);
        check("late clear", q, 32'h0000_0009);
        bus(1, 8'h00, 32'h0000_0019, q);
        bus(1, 8'h00, 32'h0000_0001, q);
        bus(0, 8'h00, '0, q);
        check("timely clear", q, 32'h0000_0001);
        watch(200, hits);
        check("off no timeout", hits, 0);
        // Restart while off zeroes the held count; flag stays from sweep
        bus(1, 8'h04, '0, q);
        bus(0, 8'h08, '0, q);
        check("flag after timeout", q, 32'h8000_0000);
        bus(1, 8'h08, 32'h0000_0001, q);
        bus(0, 8'h08, '0, q);
        check("flag cleared", q, 32'h0000_0000);
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_periods();
        t_restart();
        t_disable();
        print_verdict();
    end
endmodule

/* File: verilog/wdg_osc.sv */
// Watchdog oscillator: divides the system clock to a one-cycle tick
`timescale 1ns/1ps
module wdg_osc #(
    parameter int unsigned DIV = wdg_pkg::OSC_DIV
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Oscillator tick, one cycle wide
    output wire logic tick_o
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    generate
        if (DIV < 2 || DIV > (1 << wdg_pkg::OSC_CNT_W)) begin : g_bad_div
            $error("wdg_osc: DIV out of range");
        end
    endgenerate

    localparam logic [wdg_pkg::OSC_CNT_W-1:0] DIV_M1 =
        wdg_pkg::OSC_CNT_W'(DIV - 1);

    wdg_pkg::wdg_osc_s s_reg;
    wdg_pkg::wdg_osc_s s_next;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Runs free of any register setting, like a separate oscillator
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.div_cnt == DIV_M1) begin
            s_next.div_cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.div_cnt = s_reg.div_cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick_o = s_reg.tick;

endmodule

/* File: verilog/wdg_top.sv */
// Watchdog timer with guarded disable, classic Wishbone slave
//
// How it works
// - Counter advances only on a 1 MHz tick of its own oscillator.
// - Restart command clears the counter, starting a new period.
// - Enabled counter reaching the period pulses a full system reset.
// - Control bits 7..5 always read as zero.
// - Turn-off enable clears itself four system clocks after set.
// - Enable bit set enables; zero write works only with turn-off set.
// - Zero to enable within four clocks disables; later fails.
// - Period select picks 16K doubling to 2048K oscillator cycles.
`timescale 1ns/1ps
module wdg_top #(
    parameter int unsigned OSC_DIV     = wdg_pkg::OSC_DIV,
    parameter int unsigned BASE_PERIOD = wdg_pkg::BASE_PERIOD
) (
    // Clock and reset
    input  wire logic                     CLOCK_I,
    input  wire logic                     RESET_I,
    // Wishbone classic slave
    input  wire logic [wdg_pkg::ADR_W-1:0] WB_ADR_I,
    input  wire logic [31:0]              WB_DAT_I,
    input  wire logic [3:0]               WB_SEL_I,
    input  wire logic                     WB_WE_I,
    input  wire logic                     WB_CYC_I,
    input  wire logic                     WB_STB_I,
    output wire logic                     WB_ACK_O,
    output wire logic [31:0]              WB_DAT_O,
    // System reset request
    output wire logic                     SYS_RESET_O
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Largest period must fit the counter
    generate
        if (BASE_PERIOD < 2 ||
            BASE_PERIOD > (1 << (wdg_pkg::CNT_W - 7))) begin : g_bad_base
            $error("wdg_top: BASE_PERIOD out of range");
        end
    endgenerate

    localparam logic [wdg_pkg::CNT_W-1:0] BASE_W =
        wdg_pkg::CNT_W'(BASE_PERIOD);
    localparam logic [2:0] TOE_LOAD = 3'(wdg_pkg::TOE_HOLD_CYC - 1);
    localparam logic [4:0] RST_LOAD = 5'(wdg_pkg::RST_PULSE_CYC - 1);

    // ------------------------------------------------------------
    // Oscillator tick
    // ------------------------------------------------------------
    logic osc_tick;

    wdg_osc #(
        .DIV    (OSC_DIV)
    ) u_osc (
        .clk_i  (CLOCK_I),
        .rst_i  (RESET_I),
        .tick_o (osc_tick)
    );

    wdg_pkg::wdg_state_s s_reg;
    wdg_pkg::wdg_state_s s_next;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic                     req;
    logic                     wr_lane0;
    logic                     hit_ctrl;
    logic                     hit_rst;
    logic                     hit_stat;
    logic                     expire;
    logic [wdg_pkg::CNT_W-1:0] period_m1;

    // One request per handshake: ack drops the cycle after it rises
    assign req      = WB_CYC_I & WB_STB_I & ~s_reg.ack;
    assign wr_lane0 = req & WB_WE_I & WB_SEL_I[0];
    assign hit_ctrl = (WB_ADR_I[7:2] == wdg_pkg::OFS_CONTROL[7:2]);
    assign hit_rst  = (WB_ADR_I[7:2] == wdg_pkg::OFS_RESTART[7:2]);
    assign hit_stat = (WB_ADR_I[7:2] == wdg_pkg::OFS_STATUS[7:2]);

    // Timeout length minus one, doubling per select code
    assign period_m1 = (BASE_W << s_reg.ps) - 1'b1;

    // Period runs out on this tick; a restart in the same cycle wins
    assign expire = s_reg.en & osc_tick & (s_reg.cnt >= period_m1) &
                    ~(wr_lane0 & hit_rst);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.ack = req;
        s_next.rdata = s_reg.rdata;

        // Turn-off window ages out on system clocks
        if (s_reg.toe) begin
            if (s_reg.toe_cnt == 3'h0) begin
                s_next.toe = 1'b0;
            end else begin
                s_next.toe_cnt = s_reg.toe_cnt - 1'b1;
            end
        end

        // Reset pulse length; runs first so a new timeout reloads it
        if (s_reg.rst_out) begin
            if (s_reg.rst_cnt == 5'h0) begin
                s_next.rst_out = 1'b0;
            end else begin
                s_next.rst_cnt = s_reg.rst_cnt - 1'b1;
            end
        end

        // Counter holds while disabled, so it may not restart at zero
        if (expire) begin
            s_next.cnt = '0;
            s_next.rst_out = 1'b1;
            s_next.rst_cnt = RST_LOAD;
            s_next.wdt_flag = 1'b1;
        end else if (s_reg.en && osc_tick) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end

        // Control register write
        if (wr_lane0 && hit_ctrl) begin
            s_next.ps = WB_DAT_I[wdg_pkg::PS_LSB +: wdg_pkg::PS_W];
            if (WB_DAT_I[wdg_pkg::BIT_EN]) begin
                s_next.en = 1'b1;
            end else if (s_reg.toe) begin
                // Zero only sticks inside the live turn-off window
                s_next.en = 1'b0;
            end
            if (WB_DAT_I[wdg_pkg::BIT_TOE]) begin
                s_next.toe = 1'b1;
                s_next.toe_cnt = TOE_LOAD;
            end
        end

        // Restart command; wins over a tick in the same cycle
        if (wr_lane0 && hit_rst) begin
            s_next.cnt = '0;
        end

        // Status flag: write one clears, but a new timeout wins
        if (wr_lane0 && hit_stat && WB_DAT_I[0] && !expire) begin
            s_next.wdt_flag = 1'b0;
        end

        // Read data, unmapped reads return zero
        if (req && !WB_WE_I) begin
            s_next.rdata = 32'h0000_0000;
            if (hit_ctrl) begin
                s_next.rdata[7:5] = 3'h0;
                s_next.rdata[wdg_pkg::BIT_TOE] = s_reg.toe;
                s_next.rdata[wdg_pkg::BIT_EN] = s_reg.en;
                s_next.rdata[wdg_pkg::PS_LSB +: wdg_pkg::PS_W] = s_reg.ps;
            end else if (hit_stat) begin
                s_next.rdata[wdg_pkg::CNT_W-1:0] = s_reg.cnt;
                s_next.rdata[wdg_pkg::BIT_WDT_FLAG] = s_reg.wdt_flag;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            s_reg <= '0;
            s_reg.en <= wdg_pkg::RST_EN;
            s_reg.toe <= wdg_pkg::RST_TOE;
            s_reg.ps <= wdg_pkg::RST_PS;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flip-flops
    assign WB_ACK_O    = s_reg.ack;
    assign WB_DAT_O    = s_reg.rdata;
    assign SYS_RESET_O = s_reg.rst_out;

endmodule
